// *** tb_variable_speed_pulse_output.sv ***
// Self-checking bench for the variable speed pulse output block
`timescale 1ns/1ps
module tb_variable_speed_pulse_output;
    logic clk, rst, aw_valid, w_valid, b_ready, ar_valid, r_ready;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, pulse, dir, busy, irq;
    logic [7:0] aw_addr, ar_addr;
    logic [31:0] w_data, r_data, d, steps;
    logic [1:0] b_resp, r_resp;
    int failures, cmp_count;
    ////////////////////////////////////////////////////////////
    // Short ramp tick keeps a full ramp within a few hundred cycles
    vspo_top #(.TICK_CYC(10)) dut_u (
        .SYS_CLK_IN(clk), .SYS_RST_IN(rst),
        .S_AXI_AWADDR_IN(aw_addr), .S_AXI_AWVALID_IN(aw_valid), .S_AXI_AWREADY_OUT(aw_ready),
        .S_AXI_WDATA_IN(w_data), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(w_valid),
        .S_AXI_WREADY_OUT(w_ready), .S_AXI_BRESP_OUT(b_resp), .S_AXI_BVALID_OUT(b_valid),
        .S_AXI_BREADY_IN(b_ready), .S_AXI_ARADDR_IN(ar_addr), .S_AXI_ARVALID_IN(ar_valid),
        .S_AXI_ARREADY_OUT(ar_ready), .S_AXI_RDATA_OUT(r_data), .S_AXI_RRESP_OUT(r_resp),
        .S_AXI_RVALID_OUT(r_valid), .S_AXI_RREADY_IN(r_ready),
        .PULSE_OUT(pulse), .DIR_OUT(dir), .BUSY_OUT(busy), .IRQ_OUT(irq));
    vspo_drive_model mdl_u (.clk_in(clk), .rst_in(rst), .pulse_in(pulse), .dir_in(dir), .count_out(steps));
    ////////////////////////////////////////////////////////////
    // Clock at 25 MHz
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Bus write; ready and response are looked at mid-cycle, before the next edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = vspo_pkg::RESP_OKAY);
        logic [1:0] r;
        @(posedge clk);
        aw_addr <= a;
        w_data <= v;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        while (aw_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        aw_valid <= 1'b0;
        w_valid <= 1'b0;
        while (b_valid !== 1'b1) @(negedge clk);
        r = b_resp;
        @(posedge clk);
        b_ready <= 1'b1;
        @(posedge clk);
        b_ready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask : axi_wr
    // Bus read
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = vspo_pkg::RESP_OKAY);
        logic [1:0] r;
        @(posedge clk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        while (ar_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        ar_valid <= 1'b0;
        while (r_valid !== 1'b1) @(negedge clk);
        r = r_resp;
        v = r_data;
        @(posedge clk);
        r_ready <= 1'b1;
        @(posedge clk);
        r_ready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask : axi_rd
    // Bounded wait for the busy level
    task automatic wait_busy(input logic v, input int lim);
        int n;
        for (n = 0; n < lim && busy !== v; n++) @(negedge clk);
        chk({31'h0, busy}, {31'h0, v});
    endtask : wait_busy
    // Verdict
    task automatic wrap_up;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////
    // Watchdog, several times the expected run length
    initial
    begin
        repeat (30000) @(posedge clk);
        failures++;
        wrap_up();
    end
    // Test sequence
    initial
    begin
        {rst, aw_valid, w_valid, b_ready, ar_valid, r_ready} = 6'h20;
        {aw_addr, ar_addr, w_data} = 48'h0;
        {failures, cmp_count} = 64'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        axi_rd(vspo_pkg::ADDR_STEP, d);
        chk(d, vspo_pkg::STEP_RST);
        axi_rd(8'h20, d, vspo_pkg::RESP_SLVERR);
        chk(d, 32'h0);
        axi_wr(8'h20, 32'h1, vspo_pkg::RESP_SLVERR);
        $display("Test reset done");
        axi_wr(vspo_pkg::ADDR_IMASK, 32'h7);
        axi_wr(vspo_pkg::ADDR_FREQ, 32'h0001_86A0);
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h1);
        wait_busy(1'b1, 20);
        chk({31'h0, dir}, 32'h1);
        repeat (2000) @(posedge clk);
        axi_wr(vspo_pkg::ADDR_FREQ, 32'h0);
        wait_busy(1'b0, 10);
        chk({31'h0, dir}, 32'h0);
        axi_rd(vspo_pkg::ADDR_ISTAT, d);
        chk(d, 32'h1);
        chk({31'h0, irq}, 32'h1);
        axi_rd(vspo_pkg::ADDR_POS, d);
        chk(d, steps);
        axi_wr(vspo_pkg::ADDR_ISTAT, 32'h1);
        axi_rd(vspo_pkg::ADDR_ISTAT, d);
        chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("Test forward run done");
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        axi_wr(vspo_pkg::ADDR_FREQ, 32'hFFFE_7960);
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h1);
        wait_busy(1'b1, 20);
        chk({31'h0, dir}, 32'h0);
        repeat (2000) @(posedge clk);
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h5);
        chk({31'h0, busy}, 32'h1);
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h9);
        wait_busy(1'b0, 10);
        axi_rd(vspo_pkg::ADDR_ISTAT, d);
        chk(d, 32'h2);
        axi_rd(vspo_pkg::ADDR_POS, d);
        chk(d, steps);
        axi_wr(vspo_pkg::ADDR_ISTAT, 32'h7);
        $display("Test limit stop done");
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h0);
        axi_wr(vspo_pkg::ADDR_FREQ, 32'h0000_4E20);
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h3);
        wait_busy(1'b1, 20);
        repeat (50) @(posedge clk);
        axi_rd(vspo_pkg::ADDR_RATE, d);
        chk({31'h0, d != 32'h0 && d < 32'h4E20}, 32'h1);
        repeat (400) @(posedge clk);
        axi_rd(vspo_pkg::ADDR_RATE, d);
        chk(d, 32'h0000_4E20);
        axi_wr(vspo_pkg::ADDR_FREQ, 32'h0);
        repeat (30) @(posedge clk);
        chk({31'h0, busy}, 32'h1);
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h2);
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h3);
        wait_busy(1'b0, 1000);
        axi_rd(vspo_pkg::ADDR_ISTAT, d);
        chk(d & 32'h4, 32'h4);
        axi_wr(vspo_pkg::ADDR_ISTAT, 32'h7);
        $display("Test ramp done");
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h0);
        axi_wr(vspo_pkg::ADDR_FREQ, 32'h0001_86A0);
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h13);
        wait_busy(1'b1, 20);
        axi_rd(vspo_pkg::ADDR_RATE, d);
        chk(d, 32'h0001_86A0);
        repeat (500) @(posedge clk);
        axi_wr(vspo_pkg::ADDR_CTRL, 32'h12);
        wait_busy(1'b0, 10);
        axi_rd(vspo_pkg::ADDR_ISTAT, d);
        chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("Test legacy done");
        wrap_up();
    end
endmodule : tb_variable_speed_pulse_output

// *** vspo_assertions.sv ***
// Checker of bus handshakes and channel outputs, bound to the top module
`timescale 1ns/1ps
module vspo_checker (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    // Bus handshakes
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_WREADY_OUT,
    input wire logic [1:0] S_AXI_BRESP_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Drive side
    input wire logic PULSE_OUT,
    input wire logic DIR_OUT,
    input wire logic BUSY_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    ////////////////////////////////////////////////////////////
    // Channel outputs
    dir_idle_a: assert property (!BUSY_OUT |-> !DIR_OUT)
        else $error("Direction high while idle");
    pulse_idle_a: assert property (!BUSY_OUT |-> !PULSE_OUT)
        else $error("Pulse high while idle");
    dir_held_a: assert property (BUSY_OUT && $past(BUSY_OUT) |-> $stable(DIR_OUT))
        else $error("Direction changed during a run");
    ////////////////////////////////////////////////////////////
    // Bus timing, fixed by the hand-over latencies
    wr_ready_pair_a: assert property (S_AXI_AWREADY_OUT == S_AXI_WREADY_OUT)
        else $error("Address and data ready split");
    wr_resp_next_a: assert property (S_AXI_AWREADY_OUT |=> S_AXI_BVALID_OUT && !S_AXI_AWREADY_OUT)
        else $error("Write response late");
    b_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
        else $error("Write response dropped");
    rd_resp_next_a: assert property (S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
        else $error("Read data late");
    r_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
        else $error("Read data dropped");
    // Main scenarios reached
    run_end_c: cover property ($fell(BUSY_OUT));
    reverse_run_c: cover property (BUSY_OUT && !DIR_OUT);
    slverr_c: cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == 2'h2);
endmodule : vspo_checker

bind vspo_top vspo_checker chk_u (
    .SYS_CLK_IN(SYS_CLK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
    .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
    .S_AXI_BRESP_OUT(S_AXI_BRESP_OUT),
    .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
    .S_AXI_BREADY_IN(S_AXI_BREADY_IN),
    .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
    .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT),
    .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
    .PULSE_OUT(PULSE_OUT),
    .DIR_OUT(DIR_OUT),
    .BUSY_OUT(BUSY_OUT)
);

// *** vspo_drive_model.sv ***
// Behavioural drive that counts pulses signed by the direction line
`timescale 1ns/1ps
module vspo_drive_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Pulse and direction from the block
    input wire logic pulse_in,
    input wire logic dir_in,
    // Position seen by the drive
    output logic [31:0] count_out
);
    logic pulse_d;
    ////////////////////////////////////////////////////////////
    // Count rising pulse edges; direction is taken with the edge, as a real drive does
    always_ff @(posedge clk_in)
    begin
        pulse_d <= rst_in ? 1'b0 : pulse_in;
        if (rst_in)
            count_out <= 32'h0000_0000;
        else if (pulse_in && !pulse_d)
            count_out <= dir_in ? count_out + 32'h1 : count_out - 32'h1;
    end
endmodule : vspo_drive_model

// *** vspo_pkg.sv ***
// Constants and types shared by the variable speed pulse output block
// Function
// R1: Zero command while running with ramping on: decelerate, then stop pulses.
// R2: Zero command while running with ramping off: stop pulses at once.
// R3: Program checks busy clear and waits a scan before a nonzero restart.
// R4: Program never flips command sign while running; zero, full stop, then flip.
// R5: Activation drop while running stops pulses, ramped or immediate per ramp setting.
// R6: Stop caused by activation drop never raises the completion flag.
// R7: Limit flag of current direction stops pulses, ramped or immediate per setting.
// R8: After a limit stop, abnormal-end flag rises once operation has finished.
// R9: While busy, any further start on this channel is refused.
// R10: Program issues no command while busy remains set after activation drop.
// R11: Direction output goes inactive when execution has ended.
// R12: One global ramp enable governs every channel, no per-channel choice.
// R13: Legacy variant never ramps; soft start is left to the program.
// R14: Positive command: direction active, position counts up; negative: inactive, down.
// R15: With ramping on, speed changes during output are approached, not stepped.
// R16: Busy stays set until pulse emission has fully ceased, deceleration included.
package vspo_pkg;
    // Clock and timing
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RAMP_TICK_US = 1000;
    localparam int RAMP_TICK_CYC = RAMP_TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int TICK_W = 24;
    // Frequency limit and phase accumulator
    localparam logic [31:0] MAX_HZ = 32'h0003_0D40;
    localparam logic [32:0] PHASE_WRAP = 33'h0_017D_7840;
    localparam logic [31:0] PHASE_HALF = 32'h00BE_BC20;
    // Register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FREQ = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_POS = 8'h0C;
    localparam logic [7:0] ADDR_RATE = 8'h10;
    localparam logic [7:0] ADDR_ISTAT = 8'h14;
    localparam logic [7:0] ADDR_IMASK = 8'h18;
    localparam logic [7:0] ADDR_STEP = 8'h1C;
    // Control fields
    localparam int CTRL_W = 5;
    localparam int CTRL_ACT = 0;
    localparam int CTRL_RAMP = 1;
    localparam int CTRL_FLIM = 2;
    localparam int CTRL_RLIM = 3;
    localparam int CTRL_LEGACY = 4;
    // Status fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_DIR = 1;
    localparam int STAT_ARMED = 2;
    // Interrupt status and mask fields
    localparam int EV_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_ABN = 1;
    localparam int EV_REFUSE = 2;
    // Reset values
    localparam logic [31:0] STEP_RST = 32'h0000_03E8;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {VSPO_IDLE, VSPO_RUN, VSPO_STOP} vspo_state_t;
endpackage : vspo_pkg

// *** vspo_pulse.sv ***
// Pulse generator: phase accumulator giving a square wave at the rate in Hz
`timescale 1ns/1ps
module vspo_pulse (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Rate in Hz
    input wire logic [31:0] rate_in,
    // Pulse and one-cycle step marker
    output logic pulse_out,
    output logic step_out
);
    typedef struct packed {
        logic [31:0] acc;
        logic pulse;
        logic step;
    } vspo_pulse_st_t;

    vspo_pulse_st_t r_ff;
    vspo_pulse_st_t nxt_r;
    logic [32:0] sum;

    // Zero rate clears the phase so the line rests low with no half pulse left
    always_comb
    begin
        nxt_r = r_ff;
        sum = {1'b0, r_ff.acc} + {1'b0, rate_in};
        if (rate_in == '0)
        begin
            nxt_r.acc = '0; // R2
        end
        else if (sum >= vspo_pkg::PHASE_WRAP)
        begin
            nxt_r.acc = 32'(sum - vspo_pkg::PHASE_WRAP);
        end
        else
        begin
            nxt_r.acc = sum[31:0];
        end
        nxt_r.pulse = (nxt_r.acc >= vspo_pkg::PHASE_HALF);
        nxt_r.step = nxt_r.pulse & ~r_ff.pulse;
    end

    // State register
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            r_ff <= '0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign pulse_out = r_ff.pulse;
    assign step_out = r_ff.step;
endmodule : vspo_pulse

// *** vspo_ramp.sv ***
// Rate ramp: moves the output rate toward the target in steps per tick
`timescale 1ns/1ps
module vspo_ramp (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic [31:0] target_in,
    input wire logic [31:0] step_in,
    input wire logic ramp_en_in,
    input wire logic tick_in,
    // Result
    output logic [31:0] rate_out
);
    typedef struct packed {
        logic [31:0] rate;
    } vspo_ramp_st_t;

    vspo_ramp_st_t r_ff;
    vspo_ramp_st_t nxt_r;

    // Saturating approach; with ramping off the target is taken directly
    always_comb
    begin
        nxt_r = r_ff;
        if (!ramp_en_in)
        begin
            nxt_r.rate = target_in;
        end
        else if (tick_in)
        begin
            if (r_ff.rate < target_in)
            begin
                nxt_r.rate = (target_in - r_ff.rate > step_in) ? r_ff.rate + step_in : target_in; // R15
            end
            else if (r_ff.rate > target_in)
            begin
                nxt_r.rate = (r_ff.rate - target_in > step_in) ? r_ff.rate - step_in : target_in; // R1
            end
        end
    end

    // State register
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            r_ff <= '0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign rate_out = r_ff.rate;
endmodule : vspo_ramp

// *** vspo_top.sv ***
// Variable speed pulse output channel with AXI4-Lite registers and interrupt
`timescale 1ns/1ps
module vspo_top #(
    parameter int TICK_CYC = vspo_pkg::RAMP_TICK_CYC
) (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    // AXI4-Lite write address and data
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Drive side
    output logic PULSE_OUT,
    output logic DIR_OUT,
    output logic BUSY_OUT,
    // Interrupt
    output logic IRQ_OUT
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [vspo_pkg::CTRL_W-1:0] ctrl;
        logic [31:0] freq;
        logic [31:0] step;
        logic [vspo_pkg::EV_W-1:0] istat;
        logic [vspo_pkg::EV_W-1:0] imask;
        vspo_pkg::vspo_state_t state;
        logic dir;
        logic busy;
        logic armed;
        logic act_prev;
        logic stop_lim;
        logic stop_deact;
        logic [31:0] pos;
        logic [vspo_pkg::TICK_W-1:0] tick_cnt;
        logic tick;
        logic irq;
    } vspo_top_st_t;

    vspo_top_st_t r_ff;
    vspo_top_st_t nxt_r;

    logic [31:0] rate;
    logic pulse;
    logic step_ev;
    logic [31:0] target;
    logic ramp_en;
    logic [31:0] freq_mag;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte-lane merge of a write into a 32-bit register
    function automatic logic [31:0] vspo_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : vspo_merge

    // Whether an address names a register
    function automatic logic vspo_mapped(input logic [7:0] a);
        return (a == vspo_pkg::ADDR_CTRL) || (a == vspo_pkg::ADDR_FREQ) ||
               (a == vspo_pkg::ADDR_STAT) || (a == vspo_pkg::ADDR_POS) ||
               (a == vspo_pkg::ADDR_RATE) || (a == vspo_pkg::ADDR_ISTAT) ||
               (a == vspo_pkg::ADDR_IMASK) || (a == vspo_pkg::ADDR_STEP);
    endfunction : vspo_mapped

    ////////////////////////////////////////////////////////////////////////////
    // Speed path

    // One global enable; the legacy variant never ramps at all
    assign ramp_en = r_ff.ctrl[vspo_pkg::CTRL_RAMP] & ~r_ff.ctrl[vspo_pkg::CTRL_LEGACY]; // R12 R13

    // Magnitude of the command, clamped; sign is only read at start
    always_comb
    begin
        freq_mag = r_ff.freq[31] ? 32'(-r_ff.freq) : r_ff.freq;
        if (freq_mag > vspo_pkg::MAX_HZ)
        begin
            freq_mag = vspo_pkg::MAX_HZ;
        end
        target = (r_ff.state == vspo_pkg::VSPO_RUN) ? freq_mag : '0;
    end

    vspo_ramp u_ramp (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .target_in(target),
        .step_in(r_ff.step),
        .ramp_en_in(ramp_en),
        .tick_in(r_ff.tick),
        .rate_out(rate)
    );

    vspo_pulse u_pulse (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .rate_in(rate),
        .pulse_out(pulse),
        .step_out(step_ev)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic act;
        logic lim;
        logic act_rise;
        logic [vspo_pkg::EV_W-1:0] ev;
        logic [vspo_pkg::EV_W-1:0] clr;
        logic wr_go;
        logic rd_go;
        act = 1'b0;
        lim = 1'b0;
        act_rise = 1'b0;
        ev = '0;
        clr = '0;
        wr_go = 1'b0;
        rd_go = 1'b0;
        nxt_r = r_ff;

        // Ramp tick divider
        nxt_r.tick = 1'b0;
        if (r_ff.tick_cnt >= vspo_pkg::TICK_W'(TICK_CYC - 1))
        begin
            nxt_r.tick_cnt = '0;
            nxt_r.tick = 1'b1;
        end
        else
        begin
            nxt_r.tick_cnt = r_ff.tick_cnt + 1'b1;
        end

        // Write channel: both address and data must be offered, one at a time
        nxt_r.awready = 1'b0;
        nxt_r.wready = 1'b0;
        wr_go = S_AXI_AWVALID_IN & r_ff.awready & S_AXI_WVALID_IN & r_ff.wready;
        if (S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !r_ff.awready && !r_ff.bvalid)
        begin
            nxt_r.awready = 1'b1;
            nxt_r.wready = 1'b1;
        end
        if (r_ff.bvalid && S_AXI_BREADY_IN)
        begin
            nxt_r.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = vspo_mapped(S_AXI_AWADDR_IN) ? vspo_pkg::RESP_OKAY : vspo_pkg::RESP_SLVERR;
            unique case (S_AXI_AWADDR_IN)
                vspo_pkg::ADDR_CTRL:
                    nxt_r.ctrl = vspo_pkg::CTRL_W'(vspo_merge(32'(r_ff.ctrl), S_AXI_WDATA_IN, S_AXI_WSTRB_IN));
                vspo_pkg::ADDR_FREQ:
                    nxt_r.freq = vspo_merge(r_ff.freq, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
                vspo_pkg::ADDR_STEP:
                    nxt_r.step = vspo_merge(r_ff.step, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
                vspo_pkg::ADDR_IMASK:
                    nxt_r.imask = vspo_pkg::EV_W'(vspo_merge(32'(r_ff.imask), S_AXI_WDATA_IN, S_AXI_WSTRB_IN));
                vspo_pkg::ADDR_ISTAT:
                    clr = vspo_pkg::EV_W'(vspo_merge(32'h0, S_AXI_WDATA_IN, S_AXI_WSTRB_IN));
                default:
                    ;
            endcase
        end

        // Read channel: data registered at the address handshake
        nxt_r.arready = 1'b0;
        rd_go = S_AXI_ARVALID_IN & r_ff.arready;
        if (S_AXI_ARVALID_IN && !r_ff.arready && !r_ff.rvalid)
        begin
            nxt_r.arready = 1'b1;
        end
        if (r_ff.rvalid && S_AXI_RREADY_IN)
        begin
            nxt_r.rvalid = 1'b0;
        end
        if (rd_go)
        begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp = vspo_mapped(S_AXI_ARADDR_IN) ? vspo_pkg::RESP_OKAY : vspo_pkg::RESP_SLVERR;
            unique case (S_AXI_ARADDR_IN)
                vspo_pkg::ADDR_CTRL: nxt_r.rdata = 32'(r_ff.ctrl);
                vspo_pkg::ADDR_FREQ: nxt_r.rdata = r_ff.freq;
                vspo_pkg::ADDR_STAT: nxt_r.rdata = 32'({r_ff.armed, r_ff.dir, r_ff.busy});
                vspo_pkg::ADDR_POS: nxt_r.rdata = r_ff.pos;
                vspo_pkg::ADDR_RATE: nxt_r.rdata = rate;
                vspo_pkg::ADDR_ISTAT: nxt_r.rdata = 32'(r_ff.istat);
                vspo_pkg::ADDR_IMASK: nxt_r.rdata = 32'(r_ff.imask);
                vspo_pkg::ADDR_STEP: nxt_r.rdata = r_ff.step;
                default: nxt_r.rdata = '0;
            endcase
        end

        // Channel control
        act = r_ff.ctrl[vspo_pkg::CTRL_ACT];
        act_rise = act & ~r_ff.act_prev;
        nxt_r.act_prev = act;
        // Only the limit facing the direction of motion matters
        lim = r_ff.dir ? r_ff.ctrl[vspo_pkg::CTRL_FLIM] : r_ff.ctrl[vspo_pkg::CTRL_RLIM]; // R7
        if (act_rise)
        begin
            if (r_ff.busy)
            begin
                ev[vspo_pkg::EV_REFUSE] = 1'b1; // R9
            end
            else
            begin
                nxt_r.armed = 1'b1;
            end
        end
        unique case (r_ff.state)
            vspo_pkg::VSPO_IDLE:
            begin
                // Start: a zero-frequency stop stays armed so a nonzero write restarts
                if (act && r_ff.armed && r_ff.freq != '0)
                begin
                    nxt_r.state = vspo_pkg::VSPO_RUN;
                    nxt_r.dir = ~r_ff.freq[31]; // R14
                    nxt_r.busy = 1'b1;
                    nxt_r.stop_lim = 1'b0;
                    nxt_r.stop_deact = 1'b0;
                end
            end
            vspo_pkg::VSPO_RUN:
            begin
                // Limit outranks deactivation, which outranks a zero command
                if (lim)
                begin
                    nxt_r.state = vspo_pkg::VSPO_STOP; // R7
                    nxt_r.stop_lim = 1'b1;
                    nxt_r.armed = 1'b0;
                end
                else if (!act)
                begin
                    nxt_r.state = vspo_pkg::VSPO_STOP; // R5
                    nxt_r.stop_deact = 1'b1;
                    nxt_r.armed = 1'b0;
                end
                else if (r_ff.freq == '0)
                begin
                    nxt_r.state = vspo_pkg::VSPO_STOP; // R1 R2
                end
            end
            vspo_pkg::VSPO_STOP:
            begin
                // Busy holds until the rate, ramped or not, has reached zero
                if (rate == '0 && target == '0 && !pulse)
                begin
                    nxt_r.state = vspo_pkg::VSPO_IDLE;
                    nxt_r.busy = 1'b0; // R16
                    nxt_r.dir = 1'b0; // R11
                    ev[vspo_pkg::EV_ABN] = r_ff.stop_lim; // R8
                    ev[vspo_pkg::EV_DONE] = ~r_ff.stop_lim & ~r_ff.stop_deact; // R6
                end
            end
        endcase

        // Position follows each emitted pulse in the latched direction
        if (step_ev)
        begin
            nxt_r.pos = r_ff.dir ? r_ff.pos + 32'h0000_0001 : r_ff.pos - 32'h0000_0001; // R14
        end

        // Sticky events: a new event beats a clear in the same cycle
        nxt_r.istat = (r_ff.istat & ~clr) | ev;
        nxt_r.irq = |(nxt_r.istat & r_ff.imask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            r_ff <= '0;
            r_ff.step <= vspo_pkg::STEP_RST;
            r_ff.state <= vspo_pkg::VSPO_IDLE;
            r_ff.bresp <= vspo_pkg::RESP_OKAY;
            r_ff.rresp <= vspo_pkg::RESP_OKAY;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign S_AXI_AWREADY_OUT = r_ff.awready;
    assign S_AXI_WREADY_OUT = r_ff.wready;
    assign S_AXI_BRESP_OUT = r_ff.bresp;
    assign S_AXI_BVALID_OUT = r_ff.bvalid;
    assign S_AXI_ARREADY_OUT = r_ff.arready;
    assign S_AXI_RDATA_OUT = r_ff.rdata;
    assign S_AXI_RRESP_OUT = r_ff.rresp;
    assign S_AXI_RVALID_OUT = r_ff.rvalid;
    assign PULSE_OUT = pulse;
    assign DIR_OUT = r_ff.dir;
    assign BUSY_OUT = r_ff.busy;
    assign IRQ_OUT = r_ff.irq;
endmodule : vspo_top
